// ==== rtl/sfrd_debounce.sv ====
`timescale 1ns/1ps
// Level filter with separate rising and falling hold times.
module sfrd_debounce #(
	parameter int W = 32
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Filter input and selected hold times in cycles.
	input wire logic level_in,
	input wire logic [W-1:0] rise_cyc,
	input wire logic [W-1:0] fall_cyc,
	// Filtered level.
	output logic level_out
);
	logic level_r;
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic [W-1:0] target;
	logic [W-1:0] cnt_inc;
	logic differ;
	logic flip;

	// The count runs only while input and output disagree; a zero target flips at once.
	assign differ = level_in != level_r;
	assign target = level_in ? rise_cyc : fall_cyc;
	assign cnt_inc = cnt_r + {{(W-1){1'b0}}, 1'b1};
	assign flip = differ && (cnt_inc >= target);
	assign cnt_nxt = (differ && !flip) ? cnt_inc : {W{1'b0}};
	assign level_out = level_r;

	// Output level and hold counter.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= 1'b0;
			cnt_r <= {W{1'b0}};
		end else begin
			level_r <= flip ? level_in : level_r;
			cnt_r <= cnt_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_zero_pass: assert property (differ && target == {W{1'b0}} |=> level_r == $past(level_in))
		else $error("Zero hold time did not pass the level through.");
	chk_hold_time: assert property ($changed(level_r) |-> $past(cnt_r) + 1 >= $past(target))
		else $error("Filtered level changed before the hold time ran out.");
	chk_follow_input: assert property ($changed(level_r) |-> level_r == $past(level_in))
		else $error("Filtered level moved away from the input.");
endmodule

// ==== rtl/sfrd_pkg.sv ====
// Notes on behaviour
// - Save bit stores first fault ID on shutdown.
// - Retry wait field scales 588 ms per step.
// - Reload bit one requests nonvolatile configuration reload.
// - Debounce bit picks 2.56 us or 660 us.
// - I/O mask bit ignores 3.3 V overvoltage.
// - Core mask bit ignores core rail overvoltage.
// - Bits 7:6 set line-good rising debounce.
// - Bits 5:4 set line-good falling debounce.
// - Bits 3:2 set output-good rising debounce.
// - Bits 1:0 set output-good falling debounce.
// - Four-bit first fault ID recorded at shutdown.
package sfrd_pkg;
	// Register addresses on the management bus.
	localparam logic [15:0] ADDR_IO_RESP = 16'hFE03;
	localparam logic [15:0] ADDR_CORE_RESP = 16'hFE04;
	localparam logic [15:0] ADDR_DEB_CFG = 16'hFE05;
	// Response register fields.
	localparam int BIT_SAVE = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int BIT_RELOAD = 2;
	localparam int BIT_DEB_SEL = 1;
	localparam int BIT_MASK = 0;
	// Status pin debounce fields, low bit of each two-bit code.
	localparam int LG_RISE_LSB = 6;
	localparam int LG_FALL_LSB = 4;
	localparam int OG_RISE_LSB = 2;
	localparam int OG_FALL_LSB = 0;
	// Reset values of the response and debounce registers, and storable bits of the response registers.
	localparam logic [7:0] RESP_RST = 8'h00;
	localparam logic [7:0] DEB_RST = 8'h00;
	localparam logic [7:0] RESP_STORE_MASK = 8'h7B;
	// Fault identifiers recorded at shutdown.
	localparam logic [3:0] ID_NONE = 4'h0;
	localparam logic [3:0] ID_IO_OV = 4'h9;
	localparam logic [3:0] ID_CORE_OV = 4'hA;
	// Timing, as printed, and derived cycle counts at 250 MHz.
	localparam int CNT_W = 32;
	localparam real CLK_NS = 4.0;
	localparam real DEB_FAST_US = 2.56;
	localparam int DEB_SLOW_US = 660;
	localparam int RETRY_STEP_MS = 588;
	localparam int PIN_DEB_A_MS = 200;
	localparam int PIN_DEB_B_MS = 320;
	localparam int PIN_DEB_C_MS = 600;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;
	localparam int DEB_FAST_CYC = int'(DEB_FAST_US * NS_PER_US / CLK_NS);
	localparam int DEB_SLOW_CYC = int'(DEB_SLOW_US * NS_PER_US / CLK_NS);
	localparam int RETRY_STEP_CYC = int'(RETRY_STEP_MS * NS_PER_MS / CLK_NS);
	localparam int PIN_DEB_A_CYC = int'(PIN_DEB_A_MS * NS_PER_MS / CLK_NS);
	localparam int PIN_DEB_B_CYC = int'(PIN_DEB_B_MS * NS_PER_MS / CLK_NS);
	localparam int PIN_DEB_C_CYC = int'(PIN_DEB_C_MS * NS_PER_MS / CLK_NS);
	// Shutdown sequencer states.
	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_RETRY = 1'b1
	} sfrd_state_e;
endpackage

// ==== rtl/sfrd_top.sv ====
`timescale 1ns/1ps
// Supply overvoltage response and status pin debounce register bank.
module sfrd_top #(
	parameter int DEB_SLOW_CYC = sfrd_pkg::DEB_SLOW_CYC,
	parameter int RETRY_STEP_CYC = sfrd_pkg::RETRY_STEP_CYC,
	parameter int PIN_DEB_A_CYC = sfrd_pkg::PIN_DEB_A_CYC,
	parameter int PIN_DEB_B_CYC = sfrd_pkg::PIN_DEB_B_CYC,
	parameter int PIN_DEB_C_CYC = sfrd_pkg::PIN_DEB_C_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Decoded management bus register access.
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Raw overvoltage comparator levels from the supply monitors.
	input wire logic io_ov_pin,
	input wire logic core_ov_pin,
	// Internal status conditions and their debounced pins.
	input wire logic line_good_cond,
	input wire logic output_good_cond,
	output logic line_good_pin,
	output logic output_good_pin,
	// Fault response.
	output logic io_ov_fault,
	output logic core_ov_fault,
	output logic shutdown,
	output logic power_off,
	output logic soft_start_req,
	output logic [3:0] first_fault_id,
	// Nonvolatile memory requests.
	output logic nvm_save_req,
	output logic [3:0] nvm_save_id,
	output logic nvm_reload_req
);
	localparam int W = sfrd_pkg::CNT_W;

	// Maps a two-bit pin debounce code onto a hold time in cycles.
	function automatic logic [W-1:0] pin_deb(input logic [1:0] code);
		case (code)
			2'h1: pin_deb = W'(PIN_DEB_A_CYC);
			2'h2: pin_deb = W'(PIN_DEB_B_CYC);
			2'h3: pin_deb = W'(PIN_DEB_C_CYC);
			default: pin_deb = {W{1'b0}};
		endcase
	endfunction

	logic [7:0] io_resp_r;
	logic [7:0] core_resp_r;
	logic [7:0] deb_cfg_r;
	logic [7:0] reg_rdata_r;
	logic [1:0] sync1_r;
	logic [1:0] sync2_r;
	logic io_filt;
	logic core_filt;
	logic io_act_r;
	logic core_act_r;
	logic nvm_reload_req_r;
	logic shutdown_r;
	logic soft_start_r;
	logic nvm_save_req_r;
	logic [3:0] first_id_r;
	logic [W-1:0] retry_cnt_r;
	logic [W-1:0] retry_tgt_r;
	sfrd_pkg::sfrd_state_e st_r;
	sfrd_pkg::sfrd_state_e st_nxt;
	logic shut_evt;
	logic start_evt;

	// Address decode and write strobes.
	wire hit_io = reg_addr == sfrd_pkg::ADDR_IO_RESP;
	wire hit_core = reg_addr == sfrd_pkg::ADDR_CORE_RESP;
	wire hit_deb = reg_addr == sfrd_pkg::ADDR_DEB_CFG;
	wire wr_io = reg_wr && hit_io;
	wire wr_core = reg_wr && hit_core;
	wire wr_deb = reg_wr && hit_deb;
	wire reload_hit = (wr_io || wr_core) && reg_wdata[sfrd_pkg::BIT_RELOAD];
	wire [7:0] rd_mux = hit_io ? io_resp_r : hit_core ? core_resp_r : hit_deb ? deb_cfg_r : 8'h00;

	// Configuration registers; reload and reserved bits are never stored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_resp_r <= sfrd_pkg::RESP_RST;
			core_resp_r <= sfrd_pkg::RESP_RST;
			deb_cfg_r <= sfrd_pkg::DEB_RST;
			reg_rdata_r <= 8'h00;
			nvm_reload_req_r <= 1'b0;
		end else begin
			io_resp_r <= wr_io ? (reg_wdata & sfrd_pkg::RESP_STORE_MASK) : io_resp_r;
			core_resp_r <= wr_core ? (reg_wdata & sfrd_pkg::RESP_STORE_MASK) : core_resp_r;
			deb_cfg_r <= wr_deb ? reg_wdata : deb_cfg_r;
			reg_rdata_r <= reg_rd ? rd_mux : reg_rdata_r;
			nvm_reload_req_r <= reload_hit;
		end
	end

	// Two-stage synchronisers for the asynchronous comparator levels.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end else begin
			sync1_r <= {core_ov_pin, io_ov_pin};
			sync2_r <= sync1_r;
		end
	end

	// Overvoltage detection filters; a set debounce bit picks the fast time.
	wire [W-1:0] io_ov_cyc = io_resp_r[sfrd_pkg::BIT_DEB_SEL] ?
		W'(sfrd_pkg::DEB_FAST_CYC) : W'(DEB_SLOW_CYC);
	wire [W-1:0] core_ov_cyc = core_resp_r[sfrd_pkg::BIT_DEB_SEL] ?
		W'(sfrd_pkg::DEB_FAST_CYC) : W'(DEB_SLOW_CYC);

	sfrd_debounce #(.W(W)) u_io_filt (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(sync2_r[0]),
		.rise_cyc(io_ov_cyc),
		.fall_cyc({W{1'b0}}),
		.level_out(io_filt)
	);
	sfrd_debounce #(.W(W)) u_core_filt (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(sync2_r[1]),
		.rise_cyc(core_ov_cyc),
		.fall_cyc({W{1'b0}}),
		.level_out(core_filt)
	);

	// Status pin filters with per-edge hold times from the debounce register.
	sfrd_debounce #(.W(W)) u_line_good (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(line_good_cond),
		.rise_cyc(pin_deb(deb_cfg_r[sfrd_pkg::LG_RISE_LSB +: 2])),
		.fall_cyc(pin_deb(deb_cfg_r[sfrd_pkg::LG_FALL_LSB +: 2])),
		.level_out(line_good_pin)
	);
	sfrd_debounce #(.W(W)) u_output_good (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(output_good_cond),
		.rise_cyc(pin_deb(deb_cfg_r[sfrd_pkg::OG_RISE_LSB +: 2])),
		.fall_cyc(pin_deb(deb_cfg_r[sfrd_pkg::OG_FALL_LSB +: 2])),
		.level_out(output_good_pin)
	);

	// Faults that are acted on, and the shutdown and restart decisions.
	wire io_act_nxt = io_filt && !io_resp_r[sfrd_pkg::BIT_MASK];
	wire core_act_nxt = core_filt && !core_resp_r[sfrd_pkg::BIT_MASK];
	wire save_any = io_resp_r[sfrd_pkg::BIT_SAVE] || core_resp_r[sfrd_pkg::BIT_SAVE];
	wire [2:0] cause_retry = io_act_r ? io_resp_r[sfrd_pkg::RETRY_MSB:sfrd_pkg::RETRY_LSB] :
		core_resp_r[sfrd_pkg::RETRY_MSB:sfrd_pkg::RETRY_LSB];
	wire [W-1:0] retry_tgt_nxt = W'(cause_retry * RETRY_STEP_CYC);
	wire [3:0] cause_id = io_act_r ? sfrd_pkg::ID_IO_OV : sfrd_pkg::ID_CORE_OV;

	// Next state of the shutdown sequencer.
	always_comb begin
		st_nxt = st_r;
		shut_evt = 1'b0;
		start_evt = 1'b0;
		case (st_r)
			sfrd_pkg::ST_RUN: begin
				if (io_act_r || core_act_r) begin
					st_nxt = sfrd_pkg::ST_RETRY;
					shut_evt = 1'b1;
				end
			end
			sfrd_pkg::ST_RETRY: begin
				if (retry_cnt_r >= retry_tgt_r) begin
					st_nxt = sfrd_pkg::ST_RUN;
					start_evt = 1'b1;
				end
			end
			default: begin
				st_nxt = sfrd_pkg::ST_RUN;
			end
		endcase
	end

	// Sequencer, retry timer and first fault record.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= sfrd_pkg::ST_RUN;
			io_act_r <= 1'b0;
			core_act_r <= 1'b0;
			shutdown_r <= 1'b0;
			soft_start_r <= 1'b0;
			nvm_save_req_r <= 1'b0;
			first_id_r <= sfrd_pkg::ID_NONE;
			retry_cnt_r <= {W{1'b0}};
			retry_tgt_r <= {W{1'b0}};
		end else begin
			st_r <= st_nxt;
			io_act_r <= io_act_nxt;
			core_act_r <= core_act_nxt;
			shutdown_r <= shut_evt;
			soft_start_r <= start_evt;
			nvm_save_req_r <= shut_evt && save_any;
			first_id_r <= shut_evt ? cause_id : first_id_r;
			retry_cnt_r <= (st_r == sfrd_pkg::ST_RETRY && !start_evt) ? retry_cnt_r + 1'b1 : {W{1'b0}};
			retry_tgt_r <= shut_evt ? retry_tgt_nxt : retry_tgt_r;
		end
	end

	// Output drive.
	assign reg_rdata = reg_rdata_r;
	assign io_ov_fault = io_act_r;
	assign core_ov_fault = core_act_r;
	assign shutdown = shutdown_r;
	assign power_off = st_r == sfrd_pkg::ST_RETRY;
	assign soft_start_req = soft_start_r;
	assign first_fault_id = first_id_r;
	assign nvm_save_req = nvm_save_req_r;
	assign nvm_save_id = first_id_r;
	assign nvm_reload_req = nvm_reload_req_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_save_on_shut: assert property (shut_evt && save_any |=> nvm_save_req && nvm_save_id == $past(cause_id))
		else $error("Shutdown with save enabled did not request a store.");
	chk_no_save: assert property (!(shut_evt && save_any) |=> !nvm_save_req)
		else $error("Store requested without an enabled shutdown.");
	chk_retry_early: assert property (st_r == sfrd_pkg::ST_RETRY && retry_cnt_r < retry_tgt_r |=> !soft_start_req)
		else $error("Soft start issued before the retry wait elapsed.");
	chk_retry_zero: assert property (shutdown && retry_tgt_r == {W{1'b0}} |=> soft_start_req)
		else $error("Zero retry wait did not restart at once.");
	chk_reload_pulse: assert property (reload_hit |=> nvm_reload_req)
		else $error("Reload write did not request a reload.");
	chk_reload_idle: assert property (!reload_hit |=> !nvm_reload_req)
		else $error("Reload requested without a reload write.");
	chk_fast_select: assert property (io_resp_r[sfrd_pkg::BIT_DEB_SEL] |-> io_ov_cyc == 32'h280)
		else $error("Fast debounce select did not give 640 cycles.");
	chk_io_mask: assert property (io_resp_r[sfrd_pkg::BIT_MASK] |=> !io_ov_fault)
		else $error("Masked I/O overvoltage was acted upon.");
	chk_core_mask: assert property (core_resp_r[sfrd_pkg::BIT_MASK] |=> !core_ov_fault)
		else $error("Masked core overvoltage was acted upon.");
	chk_first_id: assert property (shut_evt && io_act_r |=> first_fault_id == sfrd_pkg::ID_IO_OV)
		else $error("I/O overvoltage shutdown recorded the wrong identifier.");

	cov_shutdown: cover property (shutdown ##[1:20] soft_start_req);
	cov_save: cover property (nvm_save_req);
	cov_reload: cover property (nvm_reload_req);
	cov_line_good: cover property ($rose(line_good_pin));
endmodule

// ==== test/sfrd_host_model.sv ====
`timescale 1ns/1ps
// Host model issuing single register writes and reads on the strobe bus.
module sfrd_host_model (
	// Clock.
	input wire logic clk,
	// Register strobe interface.
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// The bus starts idle.
	initial begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// One write; address and data are scrambled once taken so nothing relies on them.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// One read; the data is taken just after the edge that answers it.
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule

// ==== test/supply_fault_response_debounce_test.sv ====
`timescale 1ns/1ps
// Self-checking bench for the supply response and debounce bank.
module supply_fault_response_debounce_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] reg_addr;
	logic reg_wr, reg_rd;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic io_ov_pin = 1'b0, core_ov_pin = 1'b0;
	logic line_good_cond = 1'b0, output_good_cond = 1'b0;
	logic line_good_pin, output_good_pin, io_ov_fault, core_ov_fault, shutdown;
	logic power_off, soft_start_req, nvm_save_req, nvm_reload_req;
	logic [3:0] first_fault_id, nvm_save_id;
	logic [1:0] a, b, c, d;
	int n_mismatch = 0;
	int comparisons = 0;
	int deb_t[4] = '{1, 5, 8, 15};
	// Rows: address, write data, read-back, reload pulse.
	logic [32:0] reg_rows[6] = '{{16'hFE03, 8'hFF, 8'h7B, 1'b1}, {16'hFE04, 8'hC5, 8'h41, 1'b1},
		{16'hFE05, 8'hA5, 8'hA5, 1'b0}, {16'hFE06, 8'hFF, 8'h00, 1'b0},
		{16'hFE02, 8'h5A, 8'h00, 1'b0}, {16'hFE03, 8'h00, 8'h00, 1'b0}};
	// Rows: I/O response, core response, core rail raised; the last row has no retry wait.
	logic [16:0] ov_rows[7] = '{{8'h50, 8'h00, 1'b0}, {8'h0A, 8'h00, 1'b0},
		{8'h01, 8'h08, 1'b0}, {8'h40, 8'h10, 1'b1}, {8'h00, 8'h4A, 1'b1}, {8'h00, 8'h09, 1'b1},
		{8'h00, 8'h00, 1'b0}};

	// Clock of 4 ns period.
	always #2 clk = ~clk;

	sfrd_top #(.DEB_SLOW_CYC(20), .RETRY_STEP_CYC(10), .PIN_DEB_A_CYC(5), .PIN_DEB_B_CYC(8),
		.PIN_DEB_C_CYC(15)) uut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .io_ov_pin, .core_ov_pin, .line_good_cond, .output_good_cond,
		.line_good_pin, .output_good_pin, .io_ov_fault, .core_ov_fault, .shutdown, .power_off,
		.soft_start_req, .first_fault_id, .nvm_save_req, .nvm_save_id, .nvm_reload_req);
	sfrd_host_model host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);

	// Counts one comparison and reports a difference.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Steps both conditions to lvl and times each pin's change in edges.
	task automatic pins(input logic lvl, input int t_lg, input int t_og);
		int nl, no;
		nl = 0;
		no = 0;
		@(posedge clk);
		line_good_cond <= lvl;
		output_good_cond <= lvl;
		for (int i = 1; i <= 40; i++) begin
			@(posedge clk);
			#1;
			if (nl == 0 && line_good_pin === lvl) nl = i;
			if (no == 0 && output_good_pin === lvl) no = i;
		end
		chk(nl, t_lg);
		chk(no, t_og);
	endtask

	// Raises one comparator and follows the fault through shutdown and retry.
	task automatic ov(input logic [7:0] io_v, input logic [7:0] core_v, input logic use_core);
		logic [7:0] sel;
		logic [3:0] id;
		logic sd;
		int n;
		sel = use_core ? core_v : io_v;
		id = use_core ? sfrd_pkg::ID_CORE_OV : sfrd_pkg::ID_IO_OV;
		sd = 1'b0;
		n = 0;
		host.wr(16'hFE03, io_v);
		host.wr(16'hFE04, core_v);
		@(posedge clk);
		io_ov_pin <= !use_core;
		core_ov_pin <= use_core;
		while (n < 800 && (use_core ? core_ov_fault : io_ov_fault) !== 1'b1) begin
			@(posedge clk);
			#1;
			sd = sd | shutdown;
			n++;
		end
		chk(n, sel[0] ? 800 : 3 + (sel[1] ? 640 : 20));
		if (sel[0]) begin
			chk(sd, 1'b0);
		end else begin
			@(posedge clk);
			#1;
			chk({shutdown, power_off, nvm_save_req, nvm_save_id, first_fault_id},
				{1'b1, 1'b1, io_v[6] | core_v[6], id, id});
			n = 0;
			do begin
				@(posedge clk);
				io_ov_pin <= 1'b0;
				core_ov_pin <= 1'b0;
				#1;
				n++;
			end while (soft_start_req !== 1'b1 && n < 200);
			chk(n, sel[5:3] * 10 + 1);
			chk(power_off, 1'b0);
		end
		@(posedge clk);
		io_ov_pin <= 1'b0;
		core_ov_pin <= 1'b0;
		repeat (10) @(posedge clk);
	endtask

	// Watchdog well beyond the expected run of about 3600 cycles.
	initial begin
		#200000;
		n_mismatch++;
		test_done();
	end

	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		foreach (reg_rows[i]) begin
			host.wr(reg_rows[i][32:17], reg_rows[i][16:9]);
			#1;
			chk(nvm_reload_req, reg_rows[i][0]);
			host.rd(reg_rows[i][32:17], rv);
			chk(rv, reg_rows[i][8:1]);
		end
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			a = 2'(k);
			b = 2'(k + 1);
			c = 2'(k + 2);
			d = 2'(k + 3);
			host.wr(16'hFE05, {a, b, c, d});
			pins(1'b1, deb_t[a], deb_t[c]);
			pins(1'b0, deb_t[b], deb_t[d]);
		end
		$display("test pin debounce done");
		foreach (ov_rows[i]) ov(ov_rows[i][16:9], ov_rows[i][8:1], ov_rows[i][0]);
		$display("test overvoltage done");
		host.wr(16'hFE05, 8'hFF);
		@(posedge clk);
		line_good_cond <= 1'b1;
		output_good_cond <= 1'b1;
		repeat (10) @(posedge clk);
		line_good_cond <= 1'b0;
		output_good_cond <= 1'b0;
		pins(1'b1, 15, 15);
		$display("test glitch done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(first_fault_id, 4'h0);
		for (int k = 0; k < 3; k++) begin
			host.rd(16'hFE03 + 16'(k), rv);
			chk(rv, 8'h00);
		end
		$display("test reset done");
		test_done();
	end
endmodule
